// >>> rtl/frac_encode.sv
`timescale 1ns/100ps
`default_nettype none
module frac_encode
  import temp_front_pkg::*;
(
  frac_if.enc f
);
  logic [3:0] keep_mask;

  // ----------------------------------------------------------------
  // truncation, never rounding
  // ----------------------------------------------------------------
  always_comb begin
    case (f.res_sel) // [RULE6]
      RES_HALF: keep_mask = 4'h8;
      RES_QUARTER: keep_mask = 4'hC;
      RES_EIGHTH: keep_mask = 4'hE;
      RES_SIXTEENTH: keep_mask = 4'hF;
      default: keep_mask = 4'hF;
    endcase
  end

  assign f.local_byte = {f.local_raw & keep_mask, 4'h0}; // [RULE5]
  assign f.remote_byte = {f.remote_raw, 4'h0}; // [RULE5] [RULE6]
endmodule // frac_encode
`default_nettype wire

// >>> rtl/frac_if.sv
`timescale 1ns/100ps
`default_nettype none
interface frac_if;
  logic [1:0] res_sel;
  logic [3:0] local_raw;
  logic [3:0] remote_raw;
  logic [7:0] local_byte;
  logic [7:0] remote_byte;
  modport enc (input res_sel, input local_raw, input remote_raw,
               output local_byte, output remote_byte);
  modport user (output res_sel, output local_raw, output remote_raw,
                input local_byte, input remote_byte);
endinterface
`default_nettype wire

// >>> rtl/temp_front_pkg.sv
// Overview of operation
// RULE1 - an 8-bit index register selects the one data register each access targets
// RULE2 - every bus write transaction reloads the index register from its first byte
// RULE3 - host writes the index before a read to pick the register it reads
// RULE4 - index register clears to zero at reset, so a bare read targets 00
// RULE5 - fraction bytes use bits 7:4, bits 3:0 zero; local truncated by resolution
// RULE6 - two-bit field sets local resolution; remote always at the finest step
// RULE7 - each result is an integer high byte plus a fraction low byte, any range
// RULE8 - low byte read after high byte read returns that same conversion's data
package temp_front_pkg;
  // ----------------------------------------------------------------
  // register index values
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_LOCAL_HI = 8'h00;
  localparam logic [7:0] IDX_REMOTE_HI = 8'h01;
  localparam logic [7:0] IDX_REMOTE_LO = 8'h10;
  localparam logic [7:0] IDX_LOCAL_LO = 8'h15;
  localparam logic [7:0] IDX_RES = 8'h1A;
  // ----------------------------------------------------------------
  // reset values and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_RESET = 8'h00;
  localparam logic [7:0] TEMP_RESET = 8'h00;
  localparam logic [1:0] RES_SEL_RESET = 2'h0;
  localparam logic [5:0] RES_FIXED_BITS = 6'h07;
  localparam int RES_SEL_LSB = 0;
  localparam int FRAC_MSB = 7;
  localparam int FRAC_LSB = 4;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // local resolution codes: 1, 2, 3 or 4 fraction bits kept
  localparam logic [1:0] RES_HALF = 2'h0;
  localparam logic [1:0] RES_QUARTER = 2'h1;
  localparam logic [1:0] RES_EIGHTH = 2'h2;
  localparam logic [1:0] RES_SIXTEENTH = 2'h3;
endpackage

// >>> rtl/temp_reg_front.sv
`timescale 1ns/100ps
`default_nettype none
module temp_reg_front
  import temp_front_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic idx_wr,
  input wire logic [7:0] idx_byte,
  input wire logic data_wr,
  input wire logic [7:0] data_byte,
  input wire logic rd_req,
  input wire logic rd_cont,
  input wire logic conv_done,
  input wire logic [7:0] conv_local_int,
  input wire logic [3:0] conv_local_frac,
  input wire logic [7:0] conv_remote_int,
  input wire logic [3:0] conv_remote_frac,
  output logic [7:0] rd_data,
  output logic rd_ack,
  output logic [7:0] cur_index,
  output logic [1:0] local_res
);
  frac_if fi ();

  logic [7:0] idx_r, idx_nxt;
  logic [1:0] res_r, res_nxt;
  logic [7:0] lhi_r, lhi_nxt, llo_r, llo_nxt;
  logic [7:0] rhi_r, rhi_nxt, rlo_r, rlo_nxt;
  logic [7:0] held_r, held_nxt;
  logic held_remote_r, held_remote_nxt;
  logic held_v_r, held_v_nxt;
  logic [7:0] rd_data_r, rd_data_nxt;
  logic rd_ack_r, rd_ack_nxt;
  logic [7:0] rd_idx;

  function automatic logic is_low(input logic [7:0] a);
    return (a == IDX_LOCAL_LO) || (a == IDX_REMOTE_LO);
  endfunction

  assign fi.res_sel = res_r;
  assign fi.local_raw = conv_local_frac;
  assign fi.remote_raw = conv_remote_frac;

  frac_encode u_enc (
    .f(fi.enc)
  );

  // ----------------------------------------------------------------
  // index, resolution and result registers
  // ----------------------------------------------------------------
  always_comb begin
    idx_nxt = idx_r;
    res_nxt = res_r;
    lhi_nxt = lhi_r;
    llo_nxt = llo_r;
    rhi_nxt = rhi_r;
    rlo_nxt = rlo_r;
    if (idx_wr) begin
      idx_nxt = idx_byte; // [RULE1] [RULE2]
    end
    // data byte of a write lands in the resolution register only when the index selects IDX_RES
    if (data_wr && idx_r == IDX_RES) begin
      res_nxt = data_byte[RES_SEL_LSB +: 2]; // [RULE6]
    end
    if (conv_done) begin
      lhi_nxt = conv_local_int; // [RULE7]
      rhi_nxt = conv_remote_int; // [RULE7]
      llo_nxt = fi.local_byte; // [RULE5]
      rlo_nxt = fi.remote_byte; // [RULE5]
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      idx_r <= IDX_RESET; // [RULE4]
      res_r <= RES_SEL_RESET;
      lhi_r <= TEMP_RESET;
      llo_r <= TEMP_RESET;
      rhi_r <= TEMP_RESET;
      rlo_r <= TEMP_RESET;
    end else begin
      idx_r <= idx_nxt;
      res_r <= res_nxt;
      lhi_r <= lhi_nxt;
      llo_r <= llo_nxt;
      rhi_r <= rhi_nxt;
      rlo_r <= rlo_nxt;
    end
  end

  // ----------------------------------------------------------------
  // read path with coherent low-byte hold
  // ----------------------------------------------------------------
  // second byte of a two-byte read from a high byte goes to its low byte
  always_comb begin
    rd_idx = idx_r; // [RULE1] [RULE3]
    if (rd_cont && idx_r == IDX_LOCAL_HI) begin
      rd_idx = IDX_LOCAL_LO;
    end else if (rd_cont && idx_r == IDX_REMOTE_HI) begin
      rd_idx = IDX_REMOTE_LO;
    end
  end

  always_comb begin
    held_nxt = held_r;
    held_remote_nxt = held_remote_r;
    held_v_nxt = held_v_r;
    rd_data_nxt = rd_data_r;
    rd_ack_nxt = 1'b0;
    if (rd_req) begin
      rd_ack_nxt = 1'b1;
      // every read ends the hold, the matching low byte included; a high byte read sets a new one
      held_v_nxt = 1'b0; // [RULE8]
      case (rd_idx)
        IDX_LOCAL_HI: begin
          rd_data_nxt = lhi_r;
          held_nxt = llo_r; // [RULE8]
          held_remote_nxt = 1'b0;
          held_v_nxt = 1'b1;
        end
        IDX_REMOTE_HI: begin
          rd_data_nxt = rhi_r;
          held_nxt = rlo_r; // [RULE8]
          held_remote_nxt = 1'b1;
          held_v_nxt = 1'b1;
        end
        IDX_LOCAL_LO: begin
          rd_data_nxt = (held_v_r && !held_remote_r) ? held_r : llo_r; // [RULE8]
        end
        IDX_REMOTE_LO: begin
          rd_data_nxt = (held_v_r && held_remote_r) ? held_r : rlo_r; // [RULE8]
        end
        IDX_RES: begin
          rd_data_nxt = {RES_FIXED_BITS, res_r};
        end
        default: begin
          rd_data_nxt = UNMAPPED_READ;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      held_r <= TEMP_RESET;
      held_remote_r <= 1'b0;
      held_v_r <= 1'b0;
      rd_data_r <= TEMP_RESET;
      rd_ack_r <= 1'b0;
    end else begin
      held_r <= held_nxt;
      held_remote_r <= held_remote_nxt;
      held_v_r <= held_v_nxt;
      rd_data_r <= rd_data_nxt;
      rd_ack_r <= rd_ack_nxt;
    end
  end

  assign rd_data = rd_data_r;
  assign rd_ack = rd_ack_r;
  assign cur_index = idx_r;
  assign local_res = res_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_index_load: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE2]
    idx_wr |=> cur_index == $past(idx_byte))
    else $error("index not loaded by write");

  a_index_hold: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE1]
    !idx_wr |=> $stable(cur_index))
    else $error("index changed without write");

  a_reset_index: assert property (@(posedge sys_clk) // [RULE4]
    !rstn |=> (!rstn || cur_index == 8'h00) && local_res == 2'h0)
    else $error("index not zero after reset");

  a_frac_low_zero: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE5]
    rd_ack && $past(is_low(rd_idx)) |-> rd_data[3:0] == 4'h0)
    else $error("fraction low nibble not zero");

  a_local_trunc: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE6]
    conv_done && !data_wr |=> (llo_r[6:4] & ~{(res_r > 2'h0), (res_r > 2'h1),
      (res_r > 2'h2)}) == 3'h0)
    else $error("local fraction not truncated");

  a_remote_full: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE6]
    conv_done |=> rlo_r == {$past(conv_remote_frac), 4'h0})
    else $error("remote fraction altered");

  a_int_byte: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE7]
    conv_done |=> lhi_r == $past(conv_local_int) && rhi_r == $past(conv_remote_int))
    else $error("integer byte not stored");

  // shadow of the last read, kept apart from the hold logic it checks
  logic last_lhi_r, last_lhi_nxt;
  logic [7:0] last_llo_r, last_llo_nxt;

  always_comb begin
    last_lhi_nxt = last_lhi_r;
    last_llo_nxt = last_llo_r;
    if (rd_req) begin
      last_lhi_nxt = (rd_idx == IDX_LOCAL_HI);
      last_llo_nxt = llo_r;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      last_lhi_r <= 1'b0;
      last_llo_r <= TEMP_RESET;
    end else begin
      last_lhi_r <= last_lhi_nxt;
      last_llo_r <= last_llo_nxt;
    end
  end

  a_coherent_low: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE8]
    rd_req && rd_idx == IDX_LOCAL_LO && last_lhi_r |=>
      rd_ack && rd_data == $past(last_llo_r))
    else $error("low byte not from held conversion");

  a_read_ack: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE1]
    rd_req |=> rd_ack ##1 (rd_ack == $past(rd_req)))
    else $error("read not answered next cycle");
endmodule // temp_reg_front
`default_nettype wire

// >>> tb/sensor_register_pointer_fraction_tb.sv
`timescale 1ns/100ps
`default_nettype none
module sensor_register_pointer_fraction_tb;
  import temp_front_pkg::*;
  logic sys_clk, rstn, idx_wr, data_wr, rd_req, rd_cont, rd_ack, conv_done;
  logic [7:0] idx_byte, data_byte, rd_data, cur_index, li, ri, v;
  logic [3:0] lf, rf, m;
  logic [1:0] local_res;
  int err_count, samples_checked, cyc;
  temp_reg_front dut (.sys_clk(sys_clk), .rstn(rstn), .idx_wr(idx_wr),
    .idx_byte(idx_byte), .data_wr(data_wr), .data_byte(data_byte),
    .rd_req(rd_req), .rd_cont(rd_cont), .conv_done(conv_done),
    .conv_local_int(li), .conv_local_frac(lf), .conv_remote_int(ri),
    .conv_remote_frac(rf), .rd_data(rd_data), .rd_ack(rd_ack),
    .cur_index(cur_index), .local_res(local_res));
  smbus_host_model host (.sys_clk(sys_clk), .idx_wr(idx_wr), .idx_byte(idx_byte),
    .data_wr(data_wr), .data_byte(data_byte), .rd_req(rd_req),
    .rd_cont(rd_cont), .rd_ack(rd_ack), .rd_data(rd_data));
  // -------------------------------------------
  // helpers
  // -------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conv(input logic [7:0] a, input logic [3:0] b,
                      input logic [7:0] c, input logic [3:0] d);
    @(posedge sys_clk) #1;
    {li, lf, ri, rf} = {a, b, c, d};
    conv_done = 1'b1;
    @(posedge sys_clk) #1;
    conv_done = 1'b0;
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // -------------------------------------------
  // scenarios
  // -------------------------------------------
  task automatic t_reset();
    chk(cur_index, IDX_RESET);
    host.read(1'b0, v);
    chk(v, TEMP_RESET);
    host.write(IDX_RES, 1'b0, 8'h00);
    host.read(1'b0, v);
    chk(v, {RES_FIXED_BITS, RES_SEL_RESET});
    host.write(8'h02, 1'b1, 8'h5B);
    chk({6'h00, local_res}, {6'h00, RES_SEL_RESET});
    host.read(1'b0, v);
    chk(v, UNMAPPED_READ);
  endtask
  task automatic t_res();
    for (int r = 0; r < 4; r++) begin
      // upper data bits set to prove only the field is stored
      host.write(IDX_RES, 1'b1, {6'h3F, 2'(r)});
      chk(cur_index, IDX_RES);
      host.write(IDX_LOCAL_LO, 1'b1, 8'h00);
      chk({6'h00, local_res}, {6'h00, 2'(r)});
      conv(8'h19, 4'hB, 8'h4A, 4'hD);
      m = 4'(4'hF << (3 - r));
      host.read(1'b0, v);
      chk(v, {4'hB & m, 4'h0});
      host.write(IDX_REMOTE_LO, 1'b0, 8'h00);
      host.read(1'b0, v);
      chk(v, 8'hD0);
    end
  endtask
  task automatic t_pair();
    conv(8'h32, 4'h7, 8'h8B, 4'h3);
    host.write(IDX_LOCAL_HI, 1'b0, 8'h00);
    host.read(1'b0, v);
    chk(v, 8'h32);
    conv(8'h33, 4'h9, 8'h8C, 4'h5);
    host.read(1'b1, v);
    chk(v, 8'h70);
    host.write(IDX_REMOTE_HI, 1'b0, 8'h00);
    host.read(1'b0, v);
    chk(v, 8'h8C);
    conv(8'h34, 4'h1, 8'h8D, 4'h1);
    host.read(1'b1, v);
    chk(v, 8'h50);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    {rstn, conv_done, li, lf, ri, rf} = 26'h0;
    repeat (5) @(posedge sys_clk);
    #1 rstn = 1'b1;
    t_reset();
    t_res();
    t_pair();
    summarize();
  end
endmodule // sensor_register_pointer_fraction_tb
`default_nettype wire

// >>> tb/smbus_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module smbus_host_model (
  input wire logic sys_clk,
  output logic idx_wr,
  output logic [7:0] idx_byte,
  output logic data_wr,
  output logic [7:0] data_byte,
  output logic rd_req,
  output logic rd_cont,
  input wire logic rd_ack,
  input wire logic [7:0] rd_data
);
  initial begin
    {idx_wr, data_wr, rd_req, rd_cont} = 4'h0;
    idx_byte = 8'h00;
    data_byte = 8'h00;
  end
  // -------------------------------------------
  // write: index byte, then optional data byte
  // -------------------------------------------
  // the index is loaded ahead of any read that needs it
  task automatic write(input logic [7:0] idx, input logic dv, input logic [7:0] d);
    @(posedge sys_clk) #1;
    idx_wr = 1'b1;
    idx_byte = idx;
    @(posedge sys_clk) #1;
    idx_wr = 1'b0;
    // idle lines flip so a stale value never looks valid
    idx_byte = ~idx;
    data_wr = dv;
    data_byte = d;
    @(posedge sys_clk) #1;
    data_wr = 1'b0;
    data_byte = ~d;
  endtask
  task automatic read(input logic cont, output logic [7:0] d);
    int n;
    @(posedge sys_clk) #1;
    rd_req = 1'b1;
    rd_cont = cont;
    @(posedge sys_clk) #1;
    rd_req = 1'b0;
    rd_cont = 1'b0;
    n = 0;
    while (rd_ack !== 1'b1 && n < 4) begin
      @(posedge sys_clk) #1;
      n++;
    end
    d = (rd_ack === 1'b1) ? rd_data : 8'hXX;
  endtask
endmodule // smbus_host_model
`default_nettype wire
